/* verilog/tws_params.svh */
// Constants for the two-wire EEPROM write target and its controller.
// Assumes inclusion by bare name from the design files.
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
// ---------------------------------------------------------------
// Device type patterns and strap field
// ---------------------------------------------------------------
`define TWS_TYPE_ARRAY 4'ha
`define TWS_TYPE_SPECIAL 4'hb
`define TWS_TYPE_MSB 7
`define TWS_TYPE_LSB 4
`define TWS_STRAP_MSB 3
`define TWS_STRAP_LSB 1
`define TWS_DIR_BIT 0
// ---------------------------------------------------------------
// Word address fields
// ---------------------------------------------------------------
`define TWS_AREA_MSB 2
`define TWS_AREA_LSB 1
`define TWS_AREA_SECTOR 2'h0
`define TWS_AREA_UID 2'h1
`define TWS_AREA_LOCK 2'h2
`define TWS_LOCK_DATA_BIT 1
`define TWS_HI_ADDR_MSB 3
// ---------------------------------------------------------------
// Timing: self-timed write in ns, link clock period in ns
// ---------------------------------------------------------------
`define TWS_WRITE_TIME_NS 5000000
`define TWS_LINK_PERIOD_NS 160
`define TWS_WRITE_CYCLES (`TWS_WRITE_TIME_NS / `TWS_LINK_PERIOD_NS)
`define TWS_BYTE_BITS 8
`define TWS_RECOVER_PULSES 9
`define TWS_CLK_DIV 8
`endif

/* verilog/tws_pkg.sv */
// Types shared by both ends of the two-wire write link.
// Assumes tws_params.svh supplies the numeric constants.
package tws_pkg;
    typedef enum logic [2:0] {
        TWS_T_IDLE = 3'b000,
        TWS_T_DEV = 3'b001,
        TWS_T_ADDR_HI = 3'b010,
        TWS_T_ADDR_LO = 3'b011,
        TWS_T_DATA = 3'b100,
        TWS_T_IGNORE = 3'b101
    } tws_tgt_state_t;
    typedef enum logic [3:0] {
        TWS_C_IDLE = 4'h0,
        TWS_C_RECOVER = 4'h1,
        TWS_C_START = 4'h2,
        TWS_C_BIT_LO = 4'h3,
        TWS_C_BIT_HI = 4'h4,
        TWS_C_ACK_LO = 4'h5,
        TWS_C_ACK_HI = 4'h6,
        TWS_C_STOP_LO = 4'h7,
        TWS_C_STOP_HI = 4'h8,
        TWS_C_STOP_END = 4'h9
    } tws_ctl_state_t;
endpackage : tws_pkg

/* verilog/tws_bus_if.sv */
// Two-wire bus between controller and EEPROM target.
// Open-drain wires resolved here from the drive enables.
`timescale 1ns/1ps
interface tws_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_ctl_o;
    logic sda_ctl_oe;
    logic sda_tgt_o;
    logic sda_tgt_oe;
    logic scl;
    logic sda;
    // Pulled high unless an enabled driver pulls low
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_ctl_oe && !sda_ctl_o) || (sda_tgt_oe && !sda_tgt_o));
    modport ctl (output scl_o, output scl_oe, output sda_ctl_o, output sda_ctl_oe,
                 input scl, input sda);
    modport tgt (output sda_tgt_o, output sda_tgt_oe, input scl, input sda);
endinterface : tws_bus_if

/* verilog/tws_sync2.sv */
// Two flip-flop synchroniser for one level.
// Assumes the destination clock and an active-low async reset.
`timescale 1ns/1ps
module tws_sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic d,
    output logic q
);
    logic meta_reg;
    logic meta_next;
    logic q_next;
    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            q <= q_next;
        end
    end
endmodule : tws_sync2

/* verilog/tws_target.sv */
// EEPROM target end of the two-wire link: write path, array, sector, lock.
// Assumes the bus interface and a link clock well faster than the bus clock.
//
// Summary of operation
// - Data changes at clock high mean start/stop.
// - Falling data at clock high starts frame.
// - Rising data at clock high stops frame.
// - Bytes MSB first, acknowledge low ninth clock.
// - Standby after reset and after stop/write.
// - Controller recovers bus with up to nine clocks.
// - Type 1010 selects data array.
// - Address bits 3:1 must match straps.
// - Address bit 0 selects read or write; only write (bit 0 low) is acknowledged, reads are refused.
// - Acknowledge match, stay off bus otherwise.
// - Type 1011 selects special area.
// - Unique identifier never writable.
// - Sector write uses area 00, bits 4:0.
// - Lock byte bit1 to area 10 locks.
// - Locked sector leaves data unacknowledged.
// - Byte write: two addresses, data, stop.
// - Ignore bus during self-timed write.
// - Page write up to 32 bytes.
// - Page offset wraps, page bits fixed.
// - Acknowledge polling only after write done.
// - Write protect blocks array writes.
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_target
    import tws_pkg::*;
#(
    parameter int WRITE_CYCLES = `TWS_WRITE_CYCLES,
    parameter int ADDR_W = 12,
    parameter int PAGE_W = 5
) (
    input wire logic link_clk,
    input wire logic reset_n,
    tws_bus_if.tgt bus,
    input wire logic strap_select_hi,
    input wire logic strap_select_mid,
    input wire logic strap_select_lo,
    input wire logic write_protect,
    output logic write_busy,
    output logic sector_locked,
    output logic [7:0] peek_data,
    input wire logic [ADDR_W-1:0] peek_addr
);
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic scl_reg, scl_next;
    logic sda_reg, sda_next;
    tws_tgt_state_t st_reg, st_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic ack_reg, ack_next;
    logic special_reg, special_next;
    logic [1:0] area_reg, area_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [ADDR_W-1:0] pend_addr_reg, pend_addr_next;
    logic [7:0] pend_data_reg, pend_data_next;
    logic pend_we_reg, pend_we_next;
    logic pend_se_reg, pend_se_next;
    logic lock_reg, lock_next;
    logic [31:0] busy_cnt_reg, busy_cnt_next;
    logic busy_reg, busy_next;
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] sector [0:(1<<PAGE_W)-1];
    logic [7:0] peek_next;
    logic start_ev, stop_ev, rise_ev, fall_ev;
    logic [2:0] straps;
    logic [7:0] byte_in;

    // -----------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------
    tws_sync2 #(.RESET_VAL(1'b1)) u_scl (.clk(link_clk), .reset_n(reset_n),
        .d(bus.scl), .q(scl_s));
    tws_sync2 #(.RESET_VAL(1'b1)) u_sda (.clk(link_clk), .reset_n(reset_n),
        .d(bus.sda), .q(sda_s));
    tws_sync2 #(.RESET_VAL(1'b1)) u_wp (.clk(link_clk), .reset_n(reset_n),
        .d(write_protect), .q(wp_s));

    // straps default low when floating (pad pulls)
    assign straps = {strap_select_hi, strap_select_mid, strap_select_lo};
    // data edges at clock high are conditions
    assign start_ev = scl_reg && scl_s && sda_reg && !sda_s;
    assign stop_ev = scl_reg && scl_s && !sda_reg && sda_s;
    assign rise_ev = !scl_reg && scl_s;
    assign fall_ev = scl_reg && !scl_s;
    assign byte_in = {sh_reg[6:0], sda_s};

    // -----------------------------------------------------------
    // Protocol next state
    // -----------------------------------------------------------
    always_comb begin
        scl_next = scl_s;
        sda_next = sda_s;
        st_next = st_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        ack_next = ack_reg;
        special_next = special_reg;
        area_next = area_reg;
        addr_next = addr_reg;
        pend_addr_next = pend_addr_reg;
        pend_data_next = pend_data_reg;
        pend_we_next = 1'b0;
        pend_se_next = 1'b0;
        lock_next = lock_reg;
        busy_cnt_next = busy_cnt_reg;
        busy_next = busy_reg;
        if (busy_reg) begin
            st_next = TWS_T_IDLE;
            ack_next = 1'b0;
            if (busy_cnt_reg == 32'h0) begin
                busy_next = 1'b0;
            end else begin
                busy_cnt_next = busy_cnt_reg - 32'h1;
            end
        end else if (start_ev) begin
            st_next = TWS_T_DEV;
            // Clock fall after start carries no bit
            bit_next = 4'hf;
            ack_next = 1'b0;
        end else if (stop_ev) begin
            st_next = TWS_T_IDLE;
            ack_next = 1'b0;
            if (st_reg == TWS_T_DATA && pend_addr_reg != addr_reg) begin
                busy_next = 1'b1;
                busy_cnt_next = 32'(WRITE_CYCLES - 1);
            end
        end else if (st_reg != TWS_T_IDLE && st_reg != TWS_T_IGNORE) begin
            if (rise_ev && bit_reg < 4'(`TWS_BYTE_BITS)) begin
                sh_next = byte_in;
            end
            if (fall_ev) begin
                if (bit_reg == 4'(`TWS_BYTE_BITS)) begin
                    ack_next = 1'b0;
                    bit_next = 4'h0;
                    if (!ack_reg) begin
                        st_next = TWS_T_IGNORE;
                    end
                end else if (bit_reg == 4'(`TWS_BYTE_BITS - 1)) begin
                    bit_next = bit_reg + 4'h1;
                    ack_next = 1'b1;
                    case (st_reg)
                        TWS_T_DEV: begin
                            special_next = sh_reg[`TWS_TYPE_MSB:`TWS_TYPE_LSB]
                                == `TWS_TYPE_SPECIAL;
                            ack_next = (sh_reg[`TWS_TYPE_MSB:`TWS_TYPE_LSB]
                                == `TWS_TYPE_ARRAY || sh_reg[`TWS_TYPE_MSB:
                                `TWS_TYPE_LSB] == `TWS_TYPE_SPECIAL)
                                && sh_reg[`TWS_STRAP_MSB:`TWS_STRAP_LSB] == straps
                                && !sh_reg[`TWS_DIR_BIT];
                            st_next = TWS_T_ADDR_HI;
                        end
                        TWS_T_ADDR_HI: begin
                            area_next = sh_reg[`TWS_AREA_MSB:`TWS_AREA_LSB];
                            addr_next = {sh_reg[`TWS_HI_ADDR_MSB:0], addr_reg[7:0]};
                            st_next = TWS_T_ADDR_LO;
                        end
                        TWS_T_ADDR_LO: begin
                            addr_next = {addr_reg[ADDR_W-1:8], sh_reg};
                            pend_addr_next = addr_next;
                            st_next = TWS_T_DATA;
                        end
                        TWS_T_DATA: begin
                            pend_data_next = sh_reg;
                            if (special_reg) begin
                                ack_next = !lock_reg && area_reg != `TWS_AREA_UID;
                                if (ack_next && area_reg == `TWS_AREA_SECTOR) begin
                                    pend_se_next = 1'b1;
                                end
                                if (ack_next && area_reg == `TWS_AREA_LOCK
                                    && sh_reg[`TWS_LOCK_DATA_BIT]) begin
                                    lock_next = 1'b1;
                                end
                            end else begin
                                pend_we_next = !wp_s;
                            end
                            addr_next = {addr_reg[ADDR_W-1:PAGE_W],
                                addr_reg[PAGE_W-1:0] + PAGE_W'(1)};
                            pend_addr_next = addr_reg;
                        end
                        default: st_next = TWS_T_IDLE;
                    endcase
                end else begin
                    bit_next = bit_reg + 4'h1;
                end
            end
        end
        peek_next = mem[peek_addr];
    end

    // -----------------------------------------------------------
    // State registers and storage
    // -----------------------------------------------------------
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            st_reg <= TWS_T_IDLE;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            ack_reg <= 1'b0;
            special_reg <= 1'b0;
            area_reg <= 2'h0;
            addr_reg <= '0;
            pend_addr_reg <= '0;
            pend_data_reg <= 8'h00;
            pend_we_reg <= 1'b0;
            pend_se_reg <= 1'b0;
            lock_reg <= 1'b0;
            busy_cnt_reg <= 32'h0;
            busy_reg <= 1'b0;
            peek_data <= 8'h00;
        end else begin
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            st_reg <= st_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            ack_reg <= ack_next;
            special_reg <= special_next;
            area_reg <= area_next;
            addr_reg <= addr_next;
            pend_addr_reg <= pend_addr_next;
            pend_data_reg <= pend_data_next;
            pend_we_reg <= pend_we_next;
            pend_se_reg <= pend_se_next;
            lock_reg <= lock_next;
            busy_cnt_reg <= busy_cnt_next;
            busy_reg <= busy_next;
            peek_data <= peek_next;
        end
    end

    // Bytes land in the cell as received; the timed busy models programming
    always_ff @(posedge link_clk) begin
        if (pend_we_reg) begin
            mem[pend_addr_reg] <= pend_data_reg;
        end
        if (pend_se_reg) begin
            sector[pend_addr_reg[PAGE_W-1:0]] <= pend_data_reg;
        end
    end

    // acknowledge drives low in ninth clock
    assign bus.sda_tgt_o = 1'b0;
    assign bus.sda_tgt_oe = ack_reg;
    assign write_busy = busy_reg;
    assign sector_locked = lock_reg;
endmodule : tws_target

/* verilog/tws_controller.sv */
// Bus controller end: issues one write frame per request.
// Assumes core_clk drives a divided bus clock; the far end is the target.
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_controller
    import tws_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    tws_bus_if.ctl bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_recover,
    input wire logic [7:0] req_dev,
    input wire logic [7:0] req_hi,
    input wire logic [7:0] req_lo,
    input wire logic [7:0] req_data,
    output logic done,
    output logic missing_acknowledge
);
    tws_ctl_state_t st_reg, st_next;
    logic [7:0] div_reg, div_next;
    logic [7:0] sh_reg, sh_next;
    logic [2:0] bit_reg, bit_next;
    logic [1:0] idx_reg, idx_next;
    logic [3:0] pulse_reg, pulse_next;
    logic [23:0] bytes_reg, bytes_next;
    logic scl_reg, scl_next;
    logic sda_reg, sda_next;
    logic done_reg, done_next;
    logic nack_reg, nack_next;
    logic sda_s;
    logic tick;

    tws_sync2 #(.RESET_VAL(1'b1)) u_sda (.clk(core_clk), .reset_n(reset_n),
        .d(bus.sda), .q(sda_s));
    assign tick = div_reg == 8'(`TWS_CLK_DIV - 1);

    // -----------------------------------------------------------
    // Frame sequencer
    // -----------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        div_next = tick ? 8'h00 : div_reg + 8'h01;
        sh_next = sh_reg;
        bit_next = bit_reg;
        idx_next = idx_reg;
        pulse_next = pulse_reg;
        bytes_next = bytes_reg;
        scl_next = scl_reg;
        sda_next = sda_reg;
        done_next = 1'b0;
        nack_next = nack_reg;
        case (st_reg)
            TWS_C_IDLE: begin
                if (req_valid) begin
                    sh_next = req_dev;
                    bytes_next = {req_hi, req_lo, req_data};
                    idx_next = 2'h0;
                    nack_next = 1'b0;
                    pulse_next = 4'h0;
                    st_next = req_recover ? TWS_C_RECOVER : TWS_C_START;
                end
            end
            TWS_C_RECOVER: if (tick) begin
                // clock until data line is free
                scl_next = !scl_reg;
                if (scl_reg) begin
                    pulse_next = pulse_reg + 4'h1;
                    if (sda_s || pulse_reg == 4'(`TWS_RECOVER_PULSES - 1)) begin
                        st_next = TWS_C_START;
                    end
                end
            end
            TWS_C_START: if (tick) begin
                if (!scl_reg) begin
                    scl_next = 1'b1;
                    sda_next = 1'b1;
                end else begin
                    sda_next = 1'b0;
                    bit_next = 3'h7;
                    st_next = TWS_C_BIT_LO;
                end
            end
            TWS_C_BIT_LO: if (tick) begin
                // change data only with clock low
                scl_next = 1'b0;
                sda_next = sh_reg[bit_reg];
                st_next = TWS_C_BIT_HI;
            end
            TWS_C_BIT_HI: if (tick) begin
                scl_next = 1'b1;
                bit_next = bit_reg - 3'h1;
                st_next = bit_reg == 3'h0 ? TWS_C_ACK_LO : TWS_C_BIT_LO;
            end
            TWS_C_ACK_LO: if (tick) begin
                scl_next = 1'b0;
                sda_next = 1'b1;
                st_next = TWS_C_ACK_HI;
            end
            TWS_C_ACK_HI: if (tick) begin
                scl_next = 1'b1;
                if (scl_reg) begin
                    if (sda_s) begin
                        nack_next = 1'b1;
                        st_next = TWS_C_STOP_LO;
                    end else if (idx_reg == 2'h3) begin
                        st_next = TWS_C_STOP_LO;
                    end else begin
                        sh_next = bytes_reg[23:16];
                        bytes_next = {bytes_reg[15:0], 8'h00};
                        idx_next = idx_reg + 2'h1;
                        bit_next = 3'h7;
                        st_next = TWS_C_BIT_LO;
                    end
                end
            end
            TWS_C_STOP_LO: if (tick) begin
                scl_next = 1'b0;
                sda_next = 1'b0;
                st_next = TWS_C_STOP_HI;
            end
            TWS_C_STOP_HI: if (tick) begin
                scl_next = 1'b1;
                st_next = TWS_C_STOP_END;
            end
            TWS_C_STOP_END: if (tick) begin
                sda_next = 1'b1;
                done_next = 1'b1;
                st_next = TWS_C_IDLE;
            end
            default: st_next = TWS_C_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= TWS_C_IDLE;
            div_reg <= 8'h00;
            sh_reg <= 8'h00;
            bit_reg <= 3'h0;
            idx_reg <= 2'h0;
            pulse_reg <= 4'h0;
            bytes_reg <= 24'h0;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            div_reg <= div_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            idx_reg <= idx_next;
            pulse_reg <= pulse_next;
            bytes_reg <= bytes_next;
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            done_reg <= done_next;
            nack_reg <= nack_next;
        end
    end

    assign req_ready = st_reg == TWS_C_IDLE;
    assign done = done_reg;
    assign missing_acknowledge = nack_reg;
    assign bus.scl_o = scl_reg;
    assign bus.scl_oe = !scl_reg;
    assign bus.sda_ctl_o = sda_reg;
    assign bus.sda_ctl_oe = !sda_reg;
endmodule : tws_controller

/* testbench/tws_link_sva.sv */
// Link checker: watches the resolved wires and the target's data drive.
// Assumes the bench hands in both clocks, the common reset and bus nets.
`timescale 1ns/1ps
module tws_link_sva (
    input wire logic core_clk,
    input wire logic link_clk,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_tgt_o,
    input wire logic sda_tgt_oe
);
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic scl_q;
    logic sda_q;
    // --------------------------------
    // Clock count within a byte
    // --------------------------------
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        // Start or stop clears the count
        if (scl && scl_q && sda_q != sda) begin
            bit_cnt_next = 4'h0;
        end else if (scl && !scl_q) begin
            bit_cnt_next = (bit_cnt_reg == 4'h9) ? 4'h1 : bit_cnt_reg + 4'h1;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_reg <= 4'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // --------------------------------
    // Assertions
    // --------------------------------
    sequence start_s;
        scl && $fell(sda);
    endsequence
    sequence stop_s;
        scl && $rose(sda);
    endsequence
    chk_tgt_only_low: assert property (@(posedge link_clk) disable iff (!reset_n)
        sda_tgt_oe |-> !sda_tgt_o) else $error("target drove the data line high");
    chk_ack_ninth_clock: assert property (@(posedge core_clk) disable iff (!reset_n)
        scl && $past(scl) && sda_tgt_oe |-> bit_cnt_reg == 4'h9)
        else $error("target drove outside the ninth clock");
    chk_ack_release: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(scl) && sda_tgt_oe |-> ##[0:3] !sda_tgt_oe)
        else $error("target held the line after its ninth clock");
    chk_data_stable_high: assert property (@(posedge core_clk) disable iff (!reset_n)
        scl && $past(scl) && bit_cnt_reg inside {[4'h2:4'h9]} |-> $stable(sda))
        else $error("data changed while clock high");
    chk_start_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        start_s |-> scl ##[1:8] !scl) else $error("clock not lowered after start");
    chk_stop_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
        stop_s |=> (scl && sda) [*3]) else $error("bus not idle after stop");
    chk_clock_high_phase: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(scl) |-> scl [*4]) else $error("clock high phase too short");
    chk_clock_low_phase: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(scl) |-> !scl [*4]) else $error("clock low phase too short");
endmodule : tws_link_sva

/* testbench/tb_top.sv */
// Bench: controller and target joined by the bus, driven from the request side.
// Assumes both design ends, the bus interface and the link checker.
`timescale 1ns/1ps
module tb_top;
    localparam int WCYC = 400;
    localparam logic [2:0] STRAP = 3'h5;
    localparam logic [7:0] DEV_W = {4'ha, STRAP, 1'b0};
    localparam logic [7:0] DEV_S = {4'hb, STRAP, 1'b0};
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_recover = 1'b0;
    logic write_protect = 1'b0;
    logic [7:0] req_dev = 8'h00;
    logic [7:0] req_hi = 8'h00;
    logic [7:0] req_lo = 8'h00;
    logic [7:0] req_data = 8'h00;
    logic [11:0] peek_addr = 12'h000;
    logic req_ready;
    logic done;
    logic missing_acknowledge;
    logic write_busy;
    logic sector_locked;
    logic [7:0] peek_data;
    logic m;
    int n_errors = 0;
    int samples_checked = 0;
    tws_bus_if bus ();
    tws_controller u_tws_controller (.core_clk(core_clk), .reset_n(reset_n), .bus(bus),
        .req_valid(req_valid), .req_ready(req_ready), .req_recover(req_recover),
        .req_dev(req_dev), .req_hi(req_hi), .req_lo(req_lo), .req_data(req_data),
        .done(done), .missing_acknowledge(missing_acknowledge));
    tws_target #(.WRITE_CYCLES(WCYC)) u_tws_target (.link_clk(link_clk), .reset_n(reset_n),
        .bus(bus), .strap_select_hi(STRAP[2]), .strap_select_mid(STRAP[1]),
        .strap_select_lo(STRAP[0]), .write_protect(write_protect), .write_busy(write_busy),
        .sector_locked(sector_locked), .peek_data(peek_data), .peek_addr(peek_addr));
    tws_link_sva u_tws_link_sva (.core_clk(core_clk), .link_clk(link_clk),
        .reset_n(reset_n), .scl(bus.scl), .sda(bus.sda), .sda_tgt_o(bus.sda_tgt_o),
        .sda_tgt_oe(bus.sda_tgt_oe));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end
    task automatic cmp1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : cmp1
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic send(input logic [7:0] d, h, l, v, input logic rec, output logic miss);
        int n;
        @(posedge core_clk);
        req_dev <= d;
        req_hi <= h;
        req_lo <= l;
        req_data <= v;
        req_recover <= rec;
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 3000);
        cmp1(done, 1'b1);
        miss = missing_acknowledge;
    endtask : send
    task automatic wait_idle();
        int n;
        n = 0;
        // Let a launched write show busy first
        repeat (8) @(posedge core_clk);
        while (write_busy !== 1'b0 && n < 2000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        cmp1(write_busy, 1'b0);
    endtask : wait_idle
    task automatic peek(input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        peek_addr <= a;
        repeat (3) @(posedge core_clk);
        #1 cmp8(peek_data, exp);
    endtask : peek
    task automatic t_byte();
        send(DEV_W, 8'hf3, 8'h45, 8'ha5, 1'b0, m);
        cmp1(m, 1'b0);
        send(DEV_W, 8'h03, 8'h46, 8'h5a, 1'b0, m);
        cmp1(m, 1'b1);
        wait_idle();
        send(DEV_W, 8'h03, 8'h46, 8'h5a, 1'b0, m);
        cmp1(m, 1'b0);
        wait_idle();
        peek(12'h345, 8'ha5);
        peek(12'h346, 8'h5a);
        $display("test byte write ended");
    endtask : t_byte
    task automatic t_refuse();
        logic [7:0] bad [4];
        bad = '{{4'hc, STRAP, 1'b0}, {4'ha, 3'h4, 1'b0}, {4'ha, 3'h1, 1'b0}, {4'ha, STRAP, 1'b1}};
        foreach (bad[i]) begin
            send(bad[i], 8'h03, 8'h45, 8'h00, 1'b0, m);
            cmp1(m, 1'b1);
            wait_idle();
        end
        write_protect <= 1'b1;
        send(DEV_W, 8'h03, 8'h45, 8'h3c, 1'b0, m);
        wait_idle();
        write_protect <= 1'b0;
        peek(12'h345, 8'ha5);
        $display("test refusals ended");
    endtask : t_refuse
    task automatic t_sector();
        send(DEV_S, 8'h00, 8'h03, 8'h77, 1'b0, m);
        cmp1(m, 1'b0);
        wait_idle();
        send(DEV_S, 8'h02, 8'h00, 8'h11, 1'b0, m);
        cmp1(m, 1'b1);
        wait_idle();
        cmp1(sector_locked, 1'b0);
        send(DEV_S, 8'h04, 8'h00, 8'h02, 1'b0, m);
        cmp1(m, 1'b0);
        cmp1(sector_locked, 1'b1);
        wait_idle();
        send(DEV_S, 8'h00, 8'h03, 8'h55, 1'b0, m);
        cmp1(m, 1'b1);
        wait_idle();
        send(DEV_S, 8'h04, 8'h00, 8'h02, 1'b0, m);
        cmp1(m, 1'b1);
        wait_idle();
        $display("test sector ended");
    endtask : t_sector
    task automatic t_recover();
        send(DEV_W, 8'h0f, 8'hff, 8'hc3, 1'b1, m);
        cmp1(m, 1'b0);
        wait_idle();
        peek(12'hfff, 8'hc3);
        $display("test recovery ended");
    endtask : t_recover
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    initial begin
        #4000000;
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        results();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        #1 cmp1(write_busy, 1'b0);
        t_byte();
        t_refuse();
        t_sector();
        t_recover();
        results();
    end
endmodule : tb_top
